// ==== sim/dscd_cpu_model.sv ====
// Model of the pipeline side: general register file and data memory.
// Assumes read data is due exactly one cycle after a read request.
`timescale 1ns/1ps
`default_nettype none

module dscd_cpu_model (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic [3:0]                  gprReadIdx,
  output logic [dscd_pkg::DATA_W-1:0]      gprReadData,
  input  wire logic                        gprWe,
  input  wire logic [3:0]                  gprWIdx,
  input  wire logic [dscd_pkg::DATA_W-1:0] gprWData,
  input  wire dscd_pkg::dscd_mem_req_t     memReq,
  output logic [dscd_pkg::DATA_W-1:0]      memRdata
);
  import dscd_pkg::*;
  logic [DATA_W-1:0] gprFile [16];
  initial for (int i = 0; i < 16; i++) gprFile[i] = 32'h0000_40fc | (i << 8);
  assign gprReadData = gprFile[gprReadIdx];
  always @(posedge sys_clk) if (gprWe) gprFile[gprWIdx] <= gprWData;
  // Data valid one cycle only, then toggles
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) memRdata <= '0;
    else if (memReq.read) memRdata <= memReq.addr ^ 32'h5a5a_0000;
    else memRdata <= ~memRdata;
  end
endmodule
`default_nettype wire

// ==== sim/dscd_properties.sv ====
// Checker for the system-control decode block, bound to its top ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module dscd_checker (
  input wire logic                        sys_clk,
  input wire logic                        resetn,
  input wire logic                        instValid,
  input wire logic                        instReady,
  input wire logic [dscd_pkg::INSN_W-1:0] instWord,
  input wire logic [dscd_pkg::DATA_W-1:0] pcValue,
  input wire logic [3:0]                  gprReadIdx,
  input wire logic [dscd_pkg::DATA_W-1:0] gprReadData,
  input wire dscd_pkg::dscd_mem_req_t     memReq,
  input wire logic                        stateWordWe,
  input wire logic [dscd_pkg::DATA_W-1:0] stateWordOut,
  input wire logic                        testFlagWe,
  input wire logic                        illegalTrap
);
  import dscd_pkg::*;
  logic take;
  logic isPcr;
  logic isPush;
  logic isSys;
  logic isSysPush;
  assign take      = instValid && instReady;
  assign isPcr     = instWord[15:8] == 8'h8c || instWord[15:8] == 8'h8e;
  assign isPush    = instWord[15:12] == 4'h4 && instWord[3:0] == 4'h3 && instWord[7:4] inside {[4'h5:4'h7]};
  assign isSys     = instWord[3:0] == 4'ha && instWord[15:12] == 4'h0 && instWord[7:4] inside {[4'h6:4'hb]};
  assign isSysPush = instWord[15:12] == 4'h4 && instWord[3:0] == 4'h2 && instWord[7:4] inside {[4'h6:4'hb]};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_flag_untouched:
    assert property (testFlagWe == 1'b0) else $error("test flag written");
  a_reg_index_field:
    assert property (gprReadIdx == instWord[11:8]) else $error("register index not from bits 11:8");
  a_count_imm_value:
    assert property (take && instWord[15:8] == 8'h82 |=> stateWordWe && stateWordOut[27:16] == {4'h0, $past(instWord[7:0])})
    else $error("immediate count field wrong");
  a_count_reg_value:
    assert property (take && instWord[15:12] == 4'h4 && instWord[7:0] == 8'h14 |=> stateWordOut[27:16] == $past(gprReadData[11:0]))
    else $error("register count field wrong");
  a_three_cycle_busy:
    assert property (take && (isPcr || instWord[15:8] == 8'h82) |=> !instReady [*2] ##1 instReady)
    else $error("three cycle op timing wrong");
  a_pcrel_address:
    assert property (take && isPcr |=> memReq.read && memReq.addr == $past(pcValue) + {$past(instWord[7:0]), 1'b0})
    else $error("pc relative address wrong");
  a_push_two_cycle:
    assert property (take && isPush |=> !instReady ##1 instReady) else $error("control push timing wrong");
  a_sys_single_cycle:
    assert property (take && isSys |=> instReady) else $error("system move not single cycle");
  a_sys_push_addr:
    assert property (take && isSysPush |=> memReq.write && memReq.addr == $past(gprReadData) - 32'h4)
    else $error("system push address wrong");
  a_illegal_trap:
    assert property (take && instWord == 16'hffff |=> illegalTrap) else $error("unmatched word not trapped");

  c_pcrel: cover property (take && isPcr);
  c_push: cover property (take && isPush);
  c_trap: cover property (take && instWord == 16'hffff);
endmodule

bind dscd_decode_exec dscd_checker dscd_checker_i (
  .sys_clk(sys_clk), .resetn(resetn), .instValid(instValid), .instReady(instReady), .instWord(instWord),
  .pcValue(pcValue), .gprReadIdx(gprReadIdx), .gprReadData(gprReadData), .memReq(memReq),
  .stateWordWe(stateWordWe), .stateWordOut(stateWordOut), .testFlagWe(testFlagWe), .illegalTrap(illegalTrap)
);
`default_nettype wire

// ==== sim/tb.sv ====
// Testbench: issues instruction words and checks their effects.
// Assumes the cpu model answers register and memory reads.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dscd_pkg::*;
  logic              sys_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              instValid = 1'b0;
  logic [15:0]       instWord = '0;
  logic [31:0]       pcValue = '0;
  logic [31:0]       stateWordIn = 32'hffff_ffff;
  dscd_dsp_regs_t    dspRegsIn;
  dscd_mem_req_t     memReq;
  logic              instReady, gprWe, stateWordWe, testFlagWe, illegalTrap;
  logic [3:0]        gprReadIdx, gprWIdx;
  logic [5:0]        dspWe;
  logic [31:0]       gprReadData, gprWData, memRdata, dspWData, stateWordOut;
  logic [31:0]       loopStartAddr, loopEndAddr, wrapAddressingReg, p, q, a;
  int                errorCnt = 0;
  int                compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  dscd_decode_exec dscd_decode_exec_i (.sys_clk(sys_clk), .resetn(resetn), .instValid(instValid),
    .instReady(instReady), .instWord(instWord), .pcValue(pcValue), .gprReadIdx(gprReadIdx),
    .gprReadData(gprReadData), .gprWe(gprWe), .gprWIdx(gprWIdx), .gprWData(gprWData), .memReq(memReq),
    .memRdata(memRdata), .dspRegsIn(dspRegsIn), .dspWe(dspWe), .dspWData(dspWData),
    .stateWordIn(stateWordIn), .stateWordWe(stateWordWe), .stateWordOut(stateWordOut),
    .testFlagWe(testFlagWe), .illegalTrap(illegalTrap), .loopStartAddr(loopStartAddr),
    .loopEndAddr(loopEndAddr), .wrapAddressingReg(wrapAddressingReg));
  dscd_cpu_model dscd_cpu_model_i (.sys_clk(sys_clk), .resetn(resetn), .gprReadIdx(gprReadIdx),
    .gprReadData(gprReadData), .gprWe(gprWe), .gprWIdx(gprWIdx), .gprWData(gprWData),
    .memReq(memReq), .memRdata(memRdata));

  function automatic logic [31:0] gv(input int n);
    return 32'h0000_40fc | (n << 8);
  endfunction
  function automatic logic [31:0] ctl(input int s);
    return s == 0 ? wrapAddressingReg : s == 1 ? loopStartAddr : loopEndAddr;
  endfunction

  task automatic endOfTest();
    $display("compares %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Offer a word, wait for acceptance, return at the middle of cycle 1
  task automatic issue(input logic [15:0] w, input logic [31:0] pc);
    int i;
    i = 0;
    @(posedge sys_clk);
    instValid <= 1'b1;
    instWord <= w;
    pcValue <= pc;
    @(negedge sys_clk);
    while (instReady !== 1'b1) begin
      i++;
      if (i > 20) begin
        errorCnt++;
        endOfTest();
      end
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    instValid <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  initial begin
    for (int j = 0; j < 6; j++) dspRegsIn[(5 - j) * 32 +: 32] = 32'hd000_0000 + j;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    issue(16'h82a5, '0);
    chk("stateWordWe", stateWordWe, 1'b1);
    chk("stateWordOut", stateWordOut, 32'hf0a5_ffff);
    chk("illegalTrap", illegalTrap, 1'b0);
    chk("instReady", instReady, 1'b0);
    cyc(1);
    chk("instReady", instReady, 1'b0);
    cyc(1);
    chk("instReady", instReady, 1'b1);
    issue(16'h4314, '0);
    chk("stateWordOut", stateWordOut, 32'hf3fc_ffff);
    $display("test loop count done");
    for (int k = 0; k < 2; k++) begin
      issue(k == 1 ? 16'h8e10 : 16'h8c10, 32'h0000_2000);
      chk("memReq.read", memReq.read, 1'b1);
      chk("memReq.addr", memReq.addr, 32'h0000_2020);
      cyc(2);
      chk("loop addr", k == 1 ? loopEndAddr : loopStartAddr, 32'h5a5a_2020);
    end
    $display("test pc relative done");
    for (int s = 0; s < 3; s++) begin
      issue({4'h4, 4'(1 + s), 4'(5 + s), 4'he}, '0);
      chk("ctl reg", ctl(s), gv(1 + s));
      chk("gprWe", gprWe, 1'b0);
      issue({4'h0, 4'h8, 4'(5 + s), 4'h2}, '0);
      chk("gprWIdx", gprWIdx, 4'h8);
      chk("gprWe", gprWe, 1'b1);
      chk("gprWData", gprWData, gv(1 + s));
      chk("instReady", instReady, 1'b1);
      issue({4'h4, 4'(9 + s), 4'(5 + s), 4'h3}, '0);
      chk("memReq.write", memReq.write, 1'b1);
      chk("memReq.addr", memReq.addr, gv(9 + s) - 4);
      chk("memReq.wdata", memReq.wdata, gv(1 + s));
      chk("gprWData", gprWData, gv(9 + s) - 4);
      issue({4'h4, 4'(12 + s), 4'(5 + s), 4'h7}, '0);
      chk("memReq.read", memReq.read, 1'b1);
      chk("memReq.addr", memReq.addr, gv(12 + s));
      chk("gprWData", gprWData, gv(12 + s) + 4);
      cyc(2);
      chk("ctl reg", ctl(s), gv(12 + s) ^ 32'h5a5a_0000);
    end
    $display("test control moves done");
    p = gv(5);
    q = gv(6);
    for (int j = 0; j < 6; j++) begin
      issue({4'h0, 4'h1, 4'(6 + j), 4'ha}, '0);
      chk("gprWData", gprWData, 32'hd000_0000 + j);
      issue({4'h4, 4'h2, 4'(6 + j), 4'ha}, '0);
      chk("dspWe", dspWe, 6'h1 << j);
      chk("dspWData", dspWData, gv(2));
      issue({4'h4, 4'h5, 4'(6 + j), 4'h2}, '0);
      p = p - 4;
      chk("memReq.write", memReq.write, 1'b1);
      chk("memReq.addr", memReq.addr, p);
      chk("memReq.wdata", memReq.wdata, 32'hd000_0000 + j);
      chk("gprWData", gprWData, p);
      issue({4'h4, 4'h6, 4'(6 + j), 4'h6}, '0);
      chk("memReq.read", memReq.read, 1'b1);
      chk("memReq.addr", memReq.addr, q);
      chk("gprWData", gprWData, q + 4);
      cyc(2);
      chk("dspWe", dspWe, 6'h1 << j);
      chk("dspWData", dspWData, q ^ 32'h5a5a_0000);
      q = q + 4;
    end
    $display("test system moves done");
    issue(16'hffff, '0);
    chk("illegalTrap", illegalTrap, 1'b1);
    issue(16'h40f6, '0);
    chk("illegalTrap", illegalTrap, 1'b1);
    chk("testFlagWe", testFlagWe, 1'b0);
    $display("test unmatched words done");
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(negedge sys_clk);
    chk("loopStartAddr", loopStartAddr, '0);
    chk("loopEndAddr", loopEndAddr, '0);
    chk("wrapAddressingReg", wrapAddressingReg, '0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    $display("test reset done");
    endOfTest();
  end
endmodule
`default_nettype wire

// ==== verilog/dscd_decode_exec.sv ====
// System-control instruction decode and execute for the CPU core.
// Assumes the pipeline offers words with pc and general_reg_n value aligned,
// and memory read data returns exactly one cycle after a read request.
//
// Notes on behaviour
// - Every added instruction is one 16-bit word, decoded inside the core.
// - All added operations are classed as system-control instructions.
// - Core holds loop start, loop end and wrap-addressing control registers.
// - Loop iteration count is the 12-bit field in state word bits 27:16.
// - Immediate count load puts imm into bits 23:16 and clears 27:24.
// - Register count load copies general register bits 11:0 into 27:16.
// - Count loads decode from their two opcodes and take three cycles.
// - Loop start loads the word at pc plus twice disp, three cycles.
// - Loop end loads the word at pc plus twice disp, three cycles.
// - Control-to-general moves of the three control registers take one cycle.
// - General-to-control moves into the three control registers take three cycles.
// - Control pre-decrement stores: pointer minus 4, then store; two cycles.
// - Control post-increment loads: read at pointer, pointer plus 4; three cycles.
// - DSP register to general register moves take one cycle.
// - General register to DSP register moves take one cycle.
// - DSP register pre-decrement stores: pointer minus 4, then store; one cycle.
// - DSP register post-increment loads: read at pointer, pointer plus 4; one cycle.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dscd_decode_exec
  import dscd_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    instValid,
  output logic                         instReady,
  input  wire logic [dscd_pkg::INSN_W-1:0] instWord,
  input  wire logic [dscd_pkg::DATA_W-1:0] pcValue,
  output logic [3:0]                   gprReadIdx,
  input  wire logic [dscd_pkg::DATA_W-1:0] gprReadData,
  output logic                         gprWe,
  output logic [3:0]                   gprWIdx,
  output logic [dscd_pkg::DATA_W-1:0]  gprWData,
  output dscd_pkg::dscd_mem_req_t      memReq,
  input  wire logic [dscd_pkg::DATA_W-1:0] memRdata,
  input  wire dscd_pkg::dscd_dsp_regs_t    dspRegsIn,
  output logic [5:0]                   dspWe,
  output logic [dscd_pkg::DATA_W-1:0]  dspWData,
  input  wire logic [dscd_pkg::DATA_W-1:0] stateWordIn,
  output logic                         stateWordWe,
  output logic [dscd_pkg::DATA_W-1:0]  stateWordOut,
  output logic                         testFlagWe,
  output logic                         illegalTrap,
  output logic [dscd_pkg::DATA_W-1:0]  loopStartAddr,
  output logic [dscd_pkg::DATA_W-1:0]  loopEndAddr,
  output logic [dscd_pkg::DATA_W-1:0]  wrapAddressingReg
);
  import dscd_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic dscd_decode_t decodeWord(input logic [INSN_W-1:0] w);
    dscd_decode_t d;
    logic [3:0]   grp;
    logic [3:0]   mid;
    logic [3:0]   lo;
    logic         ctlRange;
    logic         sysRange;
    logic [3:0]   sysOff;
    grp      = w[15:12];
    mid      = w[7:4];
    lo       = w[3:0];
    ctlRange = (mid >= CTL_SEL_FIRST) && (mid <= CTL_SEL_LAST);
    sysRange = (mid >= SYS_SEL_FIRST) && (mid <= SYS_SEL_LAST);
    sysOff   = mid - SYS_SEL_FIRST;
    d        = '0;
    d.gprIdx = w[REG_FIELD_HI:REG_FIELD_LO];
    d.ctlSel = mid[1:0];
    d.sysSel = sysOff[2:0];
    d.op     = OP_ILLEGAL;
    // Single 16-bit word, all in the system-control class
    if (w[15:8] == HI_COUNT_IMM) begin
      d.op     = OP_COUNT_IMM;
      d.cycles = CYC_COUNT_LOAD;
    end else if (grp == GRP_LOAD && w[7:0] == LO_COUNT_REG) begin
      d.op     = OP_COUNT_REG;
      d.cycles = CYC_COUNT_LOAD;
    end else if (w[15:8] == HI_START_PCREL || w[15:8] == HI_END_PCREL) begin
      d.op     = OP_PCREL_LOAD;
      d.cycles = CYC_PCREL;
      d.ctlSel = (w[15:8] == HI_START_PCREL) ? CTL_START : CTL_END;
    end else if (grp == GRP_STORE && lo == LO_CTL_TO_GPR && ctlRange) begin
      d.op     = OP_CTL_TO_GPR;
      d.cycles = CYC_CTL_TO_GPR;
    end else if (grp == GRP_LOAD && lo == LO_GPR_TO_CTL && ctlRange) begin
      d.op     = OP_GPR_TO_CTL;
      d.cycles = CYC_GPR_TO_CTL;
    end else if (grp == GRP_LOAD && lo == LO_CTL_PUSH && ctlRange) begin
      d.op     = OP_CTL_PUSH;
      d.cycles = CYC_CTL_PUSH;
    end else if (grp == GRP_LOAD && lo == LO_CTL_POP && ctlRange) begin
      d.op     = OP_CTL_POP;
      d.cycles = CYC_CTL_POP;
    end else if (grp == GRP_STORE && lo == LO_SYS_MOVE && sysRange) begin
      d.op     = OP_SYS_TO_GPR;
      d.cycles = CYC_SYS;
    end else if (grp == GRP_LOAD && lo == LO_SYS_MOVE && sysRange) begin
      d.op     = OP_GPR_TO_SYS;
      d.cycles = CYC_SYS;
    end else if (grp == GRP_LOAD && lo == LO_SYS_PUSH && sysRange) begin
      d.op     = OP_SYS_PUSH;
      d.cycles = CYC_SYS;
    end else if (grp == GRP_LOAD && lo == LO_SYS_POP && sysRange) begin
      d.op     = OP_SYS_POP;
      d.cycles = CYC_SYS;
    end else begin
      d.op     = OP_ILLEGAL;
      d.cycles = 2'h1;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Issue and occupancy
  // ----------------------------------------------------------------
  dscd_decode_t           dec;
  logic                   accept;
  logic [1:0]             busyCount_q;
  logic [DATA_W-1:0]      ctlValue;
  logic [DATA_W-1:0]      sysValue;
  logic [DATA_W-1:0]      pcrelAddr;
  logic                   loadPend_q;
  logic                   loadIsCtl_q;
  logic [1:0]             loadCtlSel_q;
  logic [2:0]             loadSysSel_q;
  logic                   ctlWe;
  logic [1:0]             ctlWSel;
  logic [DATA_W-1:0]      ctlWData;

  assign dec        = decodeWord(instWord);
  assign instReady  = (busyCount_q == 2'h0);
  assign accept     = instValid && instReady;
  assign gprReadIdx = dec.gprIdx;
  assign testFlagWe = 1'b0;
  assign pcrelAddr  = pcValue + {23'h0, instWord[7:0], 1'b0};

  always_comb begin
    case (dec.ctlSel)
      CTL_WRAP:  ctlValue = wrapAddressingReg;
      CTL_START: ctlValue = loopStartAddr;
      CTL_END:   ctlValue = loopEndAddr;
      default:   ctlValue = REG_RESET;
    endcase
  end

  always_comb begin
    case (dec.sysSel)
      3'h0:    sysValue = dspRegsIn.dspFlags;
      3'h1:    sysValue = dspRegsIn.accumZero;
      3'h2:    sysValue = dspRegsIn.xbusInputZero;
      3'h3:    sysValue = dspRegsIn.xbusInputOne;
      3'h4:    sysValue = dspRegsIn.ybusInputZero;
      3'h5:    sysValue = dspRegsIn.ybusInputOne;
      default: sysValue = REG_RESET;
    endcase
  end

  // Holds the issue port for the instruction's cycle count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busyCount_q <= 2'h0;
    end else if (accept) begin
      busyCount_q <= dec.cycles - 2'h1;
    end else if (busyCount_q != 2'h0) begin
      busyCount_q <= busyCount_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // General register write port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gprWe    <= 1'b0;
      gprWIdx  <= 4'h0;
      gprWData <= REG_RESET;
    end else begin
      gprWe   <= 1'b0;
      gprWIdx <= dec.gprIdx;
      if (accept) begin
        case (dec.op)
          OP_CTL_TO_GPR: begin
            gprWe    <= 1'b1;
            gprWData <= ctlValue;
          end
          OP_SYS_TO_GPR: begin
            gprWe    <= 1'b1;
            gprWData <= sysValue;
          end
          OP_CTL_PUSH, OP_SYS_PUSH: begin
            gprWe    <= 1'b1;
            gprWData <= gprReadData - PTR_STEP;
          end
          OP_CTL_POP, OP_SYS_POP: begin
            gprWe    <= 1'b1;
            gprWData <= gprReadData + PTR_STEP;
          end
          default: gprWe <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memReq <= '0;
    end else begin
      memReq.read  <= 1'b0;
      memReq.write <= 1'b0;
      if (accept) begin
        case (dec.op)
          OP_PCREL_LOAD: begin
            memReq.read <= 1'b1;
            memReq.addr <= pcrelAddr;
          end
          OP_CTL_PUSH: begin
            memReq.write <= 1'b1;
            memReq.addr  <= gprReadData - PTR_STEP;
            memReq.wdata <= ctlValue;
          end
          OP_SYS_PUSH: begin
            memReq.write <= 1'b1;
            memReq.addr  <= gprReadData - PTR_STEP;
            memReq.wdata <= sysValue;
          end
          OP_CTL_POP, OP_SYS_POP: begin
            memReq.read <= 1'b1;
            memReq.addr <= gprReadData;
          end
          default: memReq.read <= 1'b0;
        endcase
      end
    end
  end

  // Tracks where returning load data goes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loadPend_q   <= 1'b0;
      loadIsCtl_q  <= 1'b0;
      loadCtlSel_q <= 2'h0;
      loadSysSel_q <= 3'h0;
    end else begin
      loadPend_q <= memReq.read;
      if (accept && (dec.op == OP_PCREL_LOAD || dec.op == OP_CTL_POP || dec.op == OP_SYS_POP)) begin
        loadIsCtl_q  <= (dec.op != OP_SYS_POP);
        loadCtlSel_q <= dec.ctlSel;
        loadSysSel_q <= dec.sysSel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb begin
    ctlWe    = 1'b0;
    ctlWSel  = dec.ctlSel;
    ctlWData = gprReadData;
    if (loadPend_q && loadIsCtl_q) begin
      ctlWe    = 1'b1;
      ctlWSel  = loadCtlSel_q;
      ctlWData = memRdata;
    end else if (accept && dec.op == OP_GPR_TO_CTL) begin
      ctlWe    = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrapAddressingReg <= REG_RESET;
      loopStartAddr     <= REG_RESET;
      loopEndAddr       <= REG_RESET;
    end else if (ctlWe) begin
      case (ctlWSel)
        CTL_WRAP:  wrapAddressingReg <= ctlWData;
        CTL_START: loopStartAddr     <= ctlWData;
        CTL_END:   loopEndAddr       <= ctlWData;
        default:   wrapAddressingReg <= wrapAddressingReg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DSP register write port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dspWe    <= 6'h00;
      dspWData <= REG_RESET;
    end else begin
      dspWe <= 6'h00;
      if (loadPend_q && !loadIsCtl_q) begin
        dspWe    <= 6'h01 << loadSysSel_q;
        dspWData <= memRdata;
      end else if (accept && dec.op == OP_GPR_TO_SYS) begin
        dspWe    <= 6'h01 << dec.sysSel;
        dspWData <= gprReadData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop count field of the state word
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateWordWe  <= 1'b0;
      stateWordOut <= REG_RESET;
    end else begin
      stateWordWe <= 1'b0;
      if (accept && dec.op == OP_COUNT_IMM) begin
        stateWordWe  <= 1'b1;
        stateWordOut <= {stateWordIn[31:28], 4'h0, instWord[7:0], stateWordIn[15:0]};
      end else if (accept && dec.op == OP_COUNT_REG) begin
        stateWordWe  <= 1'b1;
        stateWordOut <= {stateWordIn[31:28], gprReadData[COUNT_W-1:0], stateWordIn[15:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Illegal opcode report
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      illegalTrap <= 1'b0;
    end else begin
      illegalTrap <= accept && (dec.op == OP_ILLEGAL);
    end
  end

endmodule

`default_nettype wire

// ==== verilog/dscd_pkg.sv ====
// Package for the system-control decode and execute block.
// Assumes a 16-bit instruction stream and 32-bit general and DSP registers.
package dscd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int INSN_W  = 16;
  localparam int COUNT_W = 12;

  // ----------------------------------------------------------------
  // Opcode fields and patterns
  // ----------------------------------------------------------------
  localparam logic [3:0]  GRP_STORE       = 4'h0;
  localparam logic [3:0]  GRP_LOAD        = 4'h4;
  localparam logic [7:0]  HI_COUNT_IMM    = 8'h82;
  localparam logic [7:0]  HI_START_PCREL  = 8'h8c;
  localparam logic [7:0]  HI_END_PCREL    = 8'h8e;
  localparam logic [7:0]  LO_COUNT_REG    = 8'h14;
  localparam logic [3:0]  LO_CTL_TO_GPR   = 4'h2;
  localparam logic [3:0]  LO_SYS_MOVE     = 4'ha;
  localparam logic [3:0]  LO_SYS_PUSH     = 4'h2;
  localparam logic [3:0]  LO_CTL_PUSH     = 4'h3;
  localparam logic [3:0]  LO_SYS_POP      = 4'h6;
  localparam logic [3:0]  LO_CTL_POP      = 4'h7;
  localparam logic [3:0]  LO_GPR_TO_CTL   = 4'he;
  localparam logic [3:0]  CTL_SEL_FIRST   = 4'h5;
  localparam logic [3:0]  CTL_SEL_LAST    = 4'h7;
  localparam logic [3:0]  SYS_SEL_FIRST   = 4'h6;
  localparam logic [3:0]  SYS_SEL_LAST    = 4'hb;
  localparam int          REG_FIELD_HI    = 11;
  localparam int          REG_FIELD_LO    = 8;
  localparam int          COUNT_FIELD_HI  = 27;
  localparam int          COUNT_FIELD_LO  = 16;

  // ----------------------------------------------------------------
  // Cycle counts and pointer step
  // ----------------------------------------------------------------
  localparam logic [1:0]  CYC_COUNT_LOAD  = 2'h3;
  localparam logic [1:0]  CYC_PCREL       = 2'h3;
  localparam logic [1:0]  CYC_CTL_TO_GPR  = 2'h1;
  localparam logic [1:0]  CYC_GPR_TO_CTL  = 2'h3;
  localparam logic [1:0]  CYC_CTL_PUSH    = 2'h2;
  localparam logic [1:0]  CYC_CTL_POP     = 2'h3;
  localparam logic [1:0]  CYC_SYS         = 2'h1;
  localparam logic [DATA_W-1:0] PTR_STEP  = 32'h0000_0004;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ILLEGAL     = 4'b0000,
    OP_COUNT_IMM   = 4'b0001,
    OP_COUNT_REG   = 4'b0010,
    OP_PCREL_LOAD  = 4'b0011,
    OP_CTL_TO_GPR  = 4'b0100,
    OP_GPR_TO_CTL  = 4'b0101,
    OP_CTL_PUSH    = 4'b0110,
    OP_CTL_POP     = 4'b0111,
    OP_SYS_TO_GPR  = 4'b1000,
    OP_GPR_TO_SYS  = 4'b1001,
    OP_SYS_PUSH    = 4'b1010,
    OP_SYS_POP     = 4'b1011
  } dscd_op_t;

  // Control register select: wrap, loop start, loop end
  typedef enum logic [1:0] {
    CTL_WRAP  = 2'b01,
    CTL_START = 2'b10,
    CTL_END   = 2'b11
  } dscd_ctl_t;

  typedef struct packed {
    dscd_op_t   op;
    logic [1:0] cycles;
    logic [1:0] ctlSel;
    logic [2:0] sysSel;
    logic [3:0] gprIdx;
  } dscd_decode_t;

  // DSP engine registers, index 0..5: flags, accum_zero, x0, x1, y0, y1
  typedef struct packed {
    logic [DATA_W-1:0] dspFlags;
    logic [DATA_W-1:0] accumZero;
    logic [DATA_W-1:0] xbusInputZero;
    logic [DATA_W-1:0] xbusInputOne;
    logic [DATA_W-1:0] ybusInputZero;
    logic [DATA_W-1:0] ybusInputOne;
  } dscd_dsp_regs_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dscd_mem_req_t;

endpackage
